// file: pjcd_device.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
// Drive end: manual jog and command pulse decoding

module pjcd_device
  import pjcd_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = RATE_GATE_CYCLES
) (
  // Clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_in,
  // Line side from the host
  pjcd_link_if.dev                     link,
  // Configuration
  input  wire logic [2:0]              pulse_form_switch_in,
  input  wire logic                    negative_logic_in,
  input  wire logic [2:0]              position_method_setting_in,
  input  wire logic [3:0][SPEED_W-1:0] param_speed_in,
  input  wire logic [SPEED_W-1:0]      digital_switch_speed_in,
  input  wire logic [SPEED_W-1:0]      serial_speed_command_in,
  input  wire logic [SPEED_W-1:0]      speed_table_speed_in,
  // Mode status
  output logic                         pulse_mode_out,
  output logic                         jog_mode_out,
  output logic                         mode_conflict_out,
  // Manual jog command
  output logic                         jog_run_out,
  output logic                         jog_dir_out,
  output logic [SPEED_W-1:0]           jog_speed_out,
  // Position and feed rate
  output logic signed [POS_W-1:0]      position_target_out,
  output logic [RATE_W-1:0]            feed_rate_out
);

  // Units per minute per counted unit in one gate window
  localparam int unsigned RATE_SCALE = SEC_PER_MIN * (CLK_HZ / GATE_CYCLES);

  logic [10:0]         sy1_r;     // First synchroniser stage
  logic [10:0]         sy2_r;     // Second stage, safe to use
  logic                a_now;     // Phase A after polarity
  logic                b_now;     // Phase B after polarity
  logic                a_r;       // Phase A one cycle earlier
  logic                b_r;       // Phase B one cycle earlier
  logic                lstep_r;   // Line generator step earlier
  logic                jog_sel;   // Manual mode selected
  logic                pm_sel;    // Pulse mode selected
  logic                lg_act;    // Line generator in use
  logic                jfwd;      // Jog forward held
  logic                jrev;      // Jog reverse held
  logic                sp2;       // Speed select two asserted
  logic                sp3;       // Speed select three asserted
  logic                step;      // One decoded count this cycle
  logic                fwd;       // Direction of that count
  logic [WEIGHT_W-1:0] weight;    // Units per decoded count
  logic [SPEED_W-1:0]  speed_sel; // Jog speed from its source
  logic [31:0]         gate_r;    // Rate window timer
  logic [ACC_W-1:0]    acc_r;     // Units seen in this window

  // Extra multiplication from the two active-low selects
  function automatic logic [WEIGHT_W-1:0] mult_weight(input logic s2_n, input logic s3_n);
    case ({s2_n, s3_n})
      2'b01:   mult_weight = WEIGHT_X10;
      2'b10:   mult_weight = WEIGHT_X100;
      default: mult_weight = WEIGHT_X1;
    endcase
  endfunction

  // Two-flop synchroniser; reset to idle pin levels so no false edge
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sy1_r <= 11'h1f8;
      sy2_r <= 11'h1f8;
    end else begin
      sy1_r <= {link.cmd_pulse, link.cmd_sign, link.jog_mode_select_n,
                link.pulse_mode_select_n, link.jog_forward_cmd_n,
                link.jog_reverse_cmd_n, link.speed_select_second_n,
                link.speed_select_third_n, link.line_gen_active,
                link.line_gen_step, link.line_gen_dir};
      sy2_r <= sy1_r;
    end
  end

  // Synchronised levels, active-low selects inverted
  assign jog_sel = ~sy2_r[8];
  assign pm_sel  = ~sy2_r[7];
  assign jfwd    = ~sy2_r[6];
  assign jrev    = ~sy2_r[5];
  assign sp2     = ~sy2_r[4];
  assign sp3     = ~sy2_r[3];
  assign lg_act  = sy2_r[2];

  assign a_now = sy2_r[10] ^ negative_logic_in;
  assign b_now = sy2_r[9] ^ negative_logic_in;

  assign weight = mult_weight(~sp2, ~sp3);

  // Edge history for pulse and line generator decoding
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      a_r <= 1'b0;
      b_r <= 1'b0;
      lstep_r <= 1'b0;
    end else begin
      a_r <= a_now;
      b_r <= b_now;
      lstep_r <= sy2_r[1];
    end
  end

  always_comb begin
    step = 1'b0;
    fwd  = 1'b0;
    case (pulse_form_switch_in)
      FORM_SIGN_PULSE, FORM_QUAD_X1: begin
        step = a_now & ~a_r;
        fwd  = b_now;
      end
      FORM_CW_CCW: begin
        // Forward counts on the sign line, reverse on the pulse line
        step = (a_now & ~a_r) ^ (b_now & ~b_r);
        fwd  = b_now & ~b_r;
      end
      FORM_QUAD_X2: begin
        step = a_now ^ a_r;
        fwd  = ~(a_now ^ b_now);
      end
      FORM_QUAD_X4: begin
        // Both phases moving at once is dropped
        if ((a_now ^ a_r) && !(b_now ^ b_r)) begin
          step = 1'b1;
          fwd  = ~(a_now ^ b_now);
        end else if ((b_now ^ b_r) && !(a_now ^ a_r)) begin
          step = 1'b1;
          fwd  = a_now ^ b_now;
        end
      end
      default: step = 1'b0;
    endcase
  end

  // pulse mode refused beside line generator
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pulse_mode_out <= 1'b0;
      jog_mode_out <= 1'b0;
      mode_conflict_out <= 1'b0;
    end else begin
      pulse_mode_out <= pm_sel & ~lg_act;
      jog_mode_out <= jog_sel & ~pm_sel;
      mode_conflict_out <= pm_sel & lg_act;
    end
  end

  // Position target; registered pulse mode flag gates the pulse counts
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      position_target_out <= '0;
    end else if (pulse_mode_out && step) begin
      // one unit per decoded count, times weight
      position_target_out <= fwd ? position_target_out + POS_W'(weight)
                                 : position_target_out - POS_W'(weight);
    end else if (lg_act && !pm_sel && sy2_r[1] && !lstep_r) begin
      // Line generator moves one unit per rising step
      position_target_out <= sy2_r[0] ? position_target_out + POS_W'(1)
                                      : position_target_out - POS_W'(1);
    end
  end

  // units per window scaled to per minute
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      gate_r <= '0;
      acc_r <= '0;
      feed_rate_out <= '0;
    end else if (gate_r == 32'(GATE_CYCLES - 1)) begin
      gate_r <= '0;
      acc_r <= '0;
      feed_rate_out <= RATE_W'(acc_r * RATE_SCALE);
    end else begin
      gate_r <= gate_r + 32'h1;
      if (pulse_mode_out && step) begin
        acc_r <= acc_r + ACC_W'(weight);
      end
    end
  end

  always_comb begin
    case (position_method_setting_in)
      METHOD_STATION: speed_sel = param_speed_in[{sp3, sp2}];
      METHOD_DIGSW:   speed_sel = digital_switch_speed_in;
      METHOD_SERIAL:  speed_sel = serial_speed_command_in;
      METHOD_TABLE:   speed_sel = speed_table_speed_in;
      default:        speed_sel = '0;
    endcase
  end

  // run only while one jog held
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      jog_run_out   <= 1'b0;
      jog_dir_out   <= 1'b0;
      jog_speed_out <= '0;
    end else if (jog_sel && !pm_sel && (jfwd ^ jrev)) begin
      // jog honoured only in manual mode
      jog_run_out   <= 1'b1;
      jog_dir_out   <= jfwd;
      jog_speed_out <= speed_sel;
    end else begin
      // Neither or both held, manual mode off or pulse mode selected: stop
      jog_run_out   <= 1'b0;
      jog_dir_out   <= 1'b0;
      jog_speed_out <= '0;
    end
  end

endmodule

// file: pjcd_pkg.sv
// Shared constants for the jog and command pulse front end
package pjcd_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ  = 50_000_000;
  localparam int unsigned CLK_MHZ = 50;

  // Data widths
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned POS_W   = 32;
  localparam int unsigned RATE_W  = 32;
  localparam int unsigned ACC_W   = 24;
  localparam int unsigned WEIGHT_W = 8;

  // Pulse form codes, bit5 bit4 bit3 of the pulse form switch
  localparam logic [2:0] FORM_SIGN_PULSE = 3'h0;
  localparam logic [2:0] FORM_CW_CCW     = 3'h1;
  localparam logic [2:0] FORM_QUAD_X1    = 3'h2;
  localparam logic [2:0] FORM_QUAD_X2    = 3'h3;
  localparam logic [2:0] FORM_QUAD_X4    = 3'h4;

  // Extra pulse multiplication weights
  localparam logic [WEIGHT_W-1:0] WEIGHT_X1   = 8'h01;
  localparam logic [WEIGHT_W-1:0] WEIGHT_X10  = 8'h0a;
  localparam logic [WEIGHT_W-1:0] WEIGHT_X100 = 8'h64;

  // Position method values choosing the jog speed source
  localparam logic [2:0] METHOD_STATION = 3'h0;
  localparam logic [2:0] METHOD_DIGSW   = 3'h1;
  localparam logic [2:0] METHOD_SERIAL  = 3'h2;
  localparam logic [2:0] METHOD_TABLE   = 3'h4;

  // Feed rate: pulses per second times this is units per minute
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned RATE_GATE_MS = 100;
  localparam int unsigned RATE_GATE_CYCLES = RATE_GATE_MS * (CLK_HZ / 1000);

  // Host pulse timing; 5 us period meets every rate limit
  localparam int unsigned PULSE_PERIOD_NS = 5000;
  localparam int unsigned QUARTER_CYC = (PULSE_PERIOD_NS * CLK_MHZ + 3999) / 4000;
  localparam int unsigned SERVO_WAIT_MS = 30;
  localparam int unsigned SERVO_WAIT_CYC = SERVO_WAIT_MS * (CLK_HZ / 1000);

  // Host register offsets and reset value
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_CMD    = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Control register bit positions
  localparam int unsigned CB_JOG_MODE = 0;
  localparam int unsigned CB_PULSE_MODE = 1;
  localparam int unsigned CB_JOG_FWD = 2;
  localparam int unsigned CB_JOG_REV = 3;
  localparam int unsigned CB_SP2 = 4;
  localparam int unsigned CB_SP3 = 5;
  localparam int unsigned CB_SERVO_ON = 6;
  localparam int unsigned CB_LINE_GEN = 7;
  localparam int unsigned CB_FORM_LO = 8;
  localparam int unsigned CB_NEG = 11;
  localparam int unsigned CMD_DIR_BIT = 31;

endpackage

// file: pjcd_link_if.sv
`timescale 1ns/1ps
// Line-level signals from the host controller to the drive
interface pjcd_link_if;
  logic cmd_pulse;               // Command pulse line, phase A
  logic cmd_sign;                // Command sign line, phase B
  logic jog_mode_select_n;       // Manual mode select, low active
  logic pulse_mode_select_n;     // Pulse mode select, low active
  logic jog_forward_cmd_n;       // Manual forward, low active
  logic jog_reverse_cmd_n;       // Manual reverse, low active
  logic speed_select_second_n;   // Speed select two, low active
  logic speed_select_third_n;    // Speed select three, low active
  logic line_gen_active;         // Line pulse generator in use
  logic line_gen_step;           // Line generator step, one per rising edge
  logic line_gen_dir;            // Line generator direction, 1 forward

  modport host (output cmd_pulse, cmd_sign, jog_mode_select_n, pulse_mode_select_n,
                output jog_forward_cmd_n, jog_reverse_cmd_n, speed_select_second_n,
                output speed_select_third_n, line_gen_active, line_gen_step, line_gen_dir);
  modport dev  (input cmd_pulse, cmd_sign, jog_mode_select_n, pulse_mode_select_n,
                input jog_forward_cmd_n, jog_reverse_cmd_n, speed_select_second_n,
                input speed_select_third_n, line_gen_active, line_gen_step, line_gen_dir);
endinterface

// file: pjcd_host.sv
`timescale 1ns/1ps
// Host motion controller end: registers in, line signals out
module pjcd_host
  import pjcd_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES = SERVO_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Line side
  pjcd_link_if.host        link
);

  logic [15:0] ctrl_r;       // Control register
  logic [15:0] remain_r;     // Pulses still to send
  logic        dir_r;        // Burst direction, 1 forward
  logic        busy_r;       // Burst pending or running
  logic [1:0]  ph_r;         // Quarter phase inside one pulse
  logic        active_r;     // Phases are being emitted
  logic [7:0]  qcnt_r;       // Quarter period timer
  logic [20:0] wait_r;       // Servo-on settling timer
  logic        ready_r;      // Settling time has passed
  logic [2:0]  form;         // Selected pulse form
  logic        raw_pulse;    // Pulse line before polarity
  logic        raw_sign;     // Sign line before polarity
  logic        pulse_ok;     // Pulse mode may be driven

  assign form = ctrl_r[CB_FORM_LO +: 3];
  // never pulse mode with line generator
  assign pulse_ok = ctrl_r[CB_PULSE_MODE] & ~ctrl_r[CB_LINE_GEN];

  // Control register writes
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_in && addr_in == REG_CTRL) begin
      ctrl_r <= wdata_in[15:0];
    end
  end

  // hold pulses 30 ms after servo on
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !ctrl_r[CB_SERVO_ON]) begin
      wait_r  <= '0;
      ready_r <= 1'b0;
    end else if (wait_r >= 21'(WAIT_CYCLES - 1)) begin
      ready_r <= 1'b1;
    end else begin
      wait_r <= wait_r + 21'h1;
    end
  end

  // Burst sequencer: four quarter phases make one command pulse
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      remain_r <= '0;
      dir_r    <= 1'b0;
      busy_r   <= 1'b0;
      active_r <= 1'b0;
      ph_r     <= 2'h0;
      qcnt_r   <= '0;
    end else if (!busy_r) begin
      if (wr_in && addr_in == REG_CMD && wdata_in[15:0] != 16'h0) begin
        remain_r <= wdata_in[15:0];
        dir_r    <= wdata_in[CMD_DIR_BIT];
        busy_r   <= 1'b1;
        qcnt_r   <= '0;
      end
    end else if (!active_r) begin
      // Wait for servo ready and pulse mode
      if (ready_r && pulse_ok) begin
        active_r <= 1'b1;
        ph_r     <= 2'h0;
        qcnt_r   <= '0;
      end
    end else if (qcnt_r == 8'(QUARTER_CYC - 1)) begin
      // fixed period keeps rate in range
      qcnt_r <= '0;
      ph_r   <= ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        remain_r <= remain_r - 16'h1;
        if (remain_r == 16'h1) begin
          busy_r   <= 1'b0;
          active_r <= 1'b0;
        end
      end
    end else begin
      qcnt_r <= qcnt_r + 8'h1;
    end
  end

  // waveform shaped by the configured form
  always_comb begin
    raw_pulse = 1'b0;
    raw_sign  = dir_r;
    case (form)
      FORM_SIGN_PULSE: begin
        raw_pulse = active_r & ph_r[1];
      end
      FORM_CW_CCW: begin
        // Forward on the sign line, reverse on pulse
        raw_sign  = active_r & dir_r & ph_r[1];
        raw_pulse = active_r & ~dir_r & ph_r[1];
      end
      FORM_QUAD_X1, FORM_QUAD_X2, FORM_QUAD_X4: begin
        if (!active_r) begin
          raw_sign = 1'b0;
        end else if (dir_r) begin
          raw_pulse = ph_r[0] ^ ph_r[1];
          raw_sign  = ~ph_r[1];
        end else begin
          raw_pulse = ~ph_r[1];
          raw_sign  = ph_r[0] ^ ph_r[1];
        end
      end
      default: begin
        raw_sign = 1'b0;
      end
    endcase
  end

  // Registered line drivers, polarity applied to pulse and sign lines
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      link.cmd_pulse <= 1'b0;
      link.cmd_sign <= 1'b0;
      link.jog_mode_select_n <= 1'b1;
      link.pulse_mode_select_n <= 1'b1;
      link.jog_forward_cmd_n <= 1'b1;
      link.jog_reverse_cmd_n <= 1'b1;
      link.speed_select_second_n <= 1'b1;
      link.speed_select_third_n <= 1'b1;
      link.line_gen_active <= 1'b0;
      link.line_gen_step <= 1'b0;
      link.line_gen_dir <= 1'b0;
    end else begin
      link.cmd_pulse <= raw_pulse ^ ctrl_r[CB_NEG];
      link.cmd_sign <= raw_sign ^ ctrl_r[CB_NEG];
      link.jog_mode_select_n <= ~ctrl_r[CB_JOG_MODE];
      link.pulse_mode_select_n <= ~pulse_ok;
      link.jog_forward_cmd_n <= ~ctrl_r[CB_JOG_FWD];
      link.jog_reverse_cmd_n <= ~ctrl_r[CB_JOG_REV];
      link.speed_select_second_n <= ~ctrl_r[CB_SP2];
      link.speed_select_third_n <= ~ctrl_r[CB_SP3];
      link.line_gen_active <= ctrl_r[CB_LINE_GEN];
      link.line_gen_step <= 1'b0;
      link.line_gen_dir <= 1'b0;
    end
  end

  // Read data one cycle after the read strobe
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        REG_CTRL:   rdata_out <= {16'h0, ctrl_r};
        REG_CMD:    rdata_out <= {dir_r, 15'h0, remain_r};
        REG_STATUS: rdata_out <= {29'h0, active_r, busy_r, ready_r};
        default:    rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

// file: pjcd_props.sv
`timescale 1ns/1ps
// Watches the link pins and the main drive outputs
module pjcd_props
  import pjcd_pkg::*;
(
  // Clock and reset
  input wire logic                    clk_sys_in,
  input wire logic                    rst_in,
  // Link pins
  input wire logic                    jog_mode_select_n,
  input wire logic                    pulse_mode_select_n,
  input wire logic                    jog_forward_cmd_n,
  input wire logic                    jog_reverse_cmd_n,
  input wire logic                    speed_select_second_n,
  input wire logic                    speed_select_third_n,
  // Drive outputs
  input wire logic                    pulse_mode_out,
  input wire logic                    mode_conflict_out,
  input wire logic                    jog_run_out,
  input wire logic                    jog_dir_out,
  input wire logic signed [POS_W-1:0] position_target_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  logic signed [POS_W-1:0] pos_prev_r;  // Target one cycle ago
  logic signed [POS_W-1:0] step;        // Travel in this cycle

  // Previous target, cleared with the drive
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pos_prev_r <= '0;
    end else begin
      pos_prev_r <= position_target_out;
    end
  end
  assign step = position_target_out - pos_prev_r;

  // Pipeline is three deep, so four stable cycles settle the outputs
  chk_idle_hold: assert property (!pulse_mode_out [*3] |=> $stable(position_target_out))
    else $error("target moved outside pulse mode");
  chk_mode_excl: assert property (pulse_mode_out |-> !mode_conflict_out)
    else $error("pulse mode and conflict together");
  chk_sel_pulse: assert property (pulse_mode_select_n [*4] |-> !pulse_mode_out)
    else $error("pulse mode without selection");
  chk_jog_stop: assert property ((jog_forward_cmd_n == jog_reverse_cmd_n) [*4] |-> !jog_run_out)
    else $error("jog runs without one direction");
  chk_jog_mode: assert property (jog_mode_select_n [*4] |-> !jog_run_out)
    else $error("jog runs outside manual mode");
  chk_jog_run: assert property ((!jog_mode_select_n && pulse_mode_select_n && $stable(jog_forward_cmd_n)
    && jog_forward_cmd_n != jog_reverse_cmd_n) [*4] |-> jog_run_out && jog_dir_out == jog_reverse_cmd_n)
    else $error("jog not running in held direction");
  // Both selects equal means a unit weight
  chk_unit_step: assert property ((speed_select_second_n == speed_select_third_n) [*6]
    |-> step inside {-32'sh1, 32'sh0, 32'sh1})
    else $error("unit weight step wrong");
  chk_ten_step: assert property ((!speed_select_second_n && speed_select_third_n) [*6]
    |-> step inside {-32'sha, 32'sh0, 32'sha})
    else $error("weight ten step wrong");
  chk_hundred_step: assert property ((speed_select_second_n && !speed_select_third_n) [*6]
    |-> step inside {-32'sh64, 32'sh0, 32'sh64})
    else $error("weight hundred step wrong");
endmodule

// file: pjcd_test.sv
`timescale 1ns/1ps
// Bench: host and drive joined by one link, plus a bench-driven link
module pjcd_test;
  import pjcd_pkg::*;
  // One burst: form, polarity, selects, count, forward, travel
  typedef struct {
    logic [2:0]  form;
    logic        neg;
    logic        sp2;
    logic        sp3;
    logic [15:0] cnt;
    logic        fwd;
    logic [31:0] delta;
  } pjcd_row_type;
  pjcd_row_type rows [8] = '{
    '{FORM_SIGN_PULSE, 1'b0, 1'b0, 1'b0, 16'h3, 1'b1, 32'sh3},
    '{FORM_SIGN_PULSE, 1'b1, 1'b0, 1'b0, 16'h2, 1'b0, -32'sh2},
    '{FORM_CW_CCW, 1'b0, 1'b0, 1'b0, 16'h2, 1'b1, 32'sh2},
    '{FORM_CW_CCW, 1'b1, 1'b1, 1'b0, 16'h2, 1'b0, -32'sh14},
    '{FORM_QUAD_X1, 1'b0, 1'b0, 1'b0, 16'h2, 1'b1, 32'sh2},
    '{FORM_QUAD_X2, 1'b1, 1'b0, 1'b1, 16'h1, 1'b0, -32'shc8},
    '{FORM_QUAD_X4, 1'b0, 1'b1, 1'b1, 16'h2, 1'b1, 32'sh8},
    '{FORM_QUAD_X4, 1'b1, 1'b0, 1'b0, 16'h1, 1'b0, -32'sh4}};
  // Jog cases: method and speed, then control word and run level
  logic [2:0]  mtab [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
  logic [15:0] stab [5] = '{16'h0111, 16'h0101, 16'h0103, 16'h0104, 16'h0};
  logic [31:0] jtab [5] = '{32'h19, 32'h1d, 32'h11, 32'h07, 32'h04};
  logic        jrun [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  logic                      clk_sys_in;  // System clock
  logic                      rst_in;      // Synchronous reset
  logic [7:0]                addr_in;     // Register address
  logic [31:0]               wdata_in;    // Register write data
  logic                      wr_in;       // Write strobe
  logic                      rd_in;       // Read strobe
  logic [31:0]               rdata_out;   // Register read data
  logic [2:0]                form;        // Drive pulse form
  logic                      neg;         // Drive polarity
  logic [2:0]                method;      // Jog speed source
  logic [3:0][SPEED_W-1:0]   pspeed;      // Four preset speeds
  logic                      pulse_mode_out, jog_mode_out, mode_conflict_out;
  logic                      jog_run_out, jog_dir_out;
  logic [SPEED_W-1:0]        jog_speed_out;
  logic signed [POS_W-1:0]   position_target_out;
  logic [RATE_W-1:0]         feed_rate_out;
  logic                      pm2, mc2;    // Second drive mode outputs
  logic [31:0]               rd, ctrl, p0;
  int                        error_cnt = 0;
  int                        num_checks = 0;

  pjcd_link_if link ();
  pjcd_link_if link2 ();
  pjcd_host #(.WAIT_CYCLES(20)) i_pjcd_host (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .link(link));
  pjcd_device #(.GATE_CYCLES(1000)) i_pjcd_device (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .link(link), .pulse_form_switch_in(form), .negative_logic_in(neg),
    .position_method_setting_in(method), .param_speed_in(pspeed),
    .digital_switch_speed_in(pspeed[0]), .serial_speed_command_in(pspeed[2]),
    .speed_table_speed_in(pspeed[3]), .pulse_mode_out(pulse_mode_out),
    .jog_mode_out(jog_mode_out), .mode_conflict_out(mode_conflict_out),
    .jog_run_out(jog_run_out), .jog_dir_out(jog_dir_out), .jog_speed_out(jog_speed_out),
    .position_target_out(position_target_out), .feed_rate_out(feed_rate_out));
  // Second drive faces the bench, which breaks the exclusion
  pjcd_device #(.GATE_CYCLES(1000)) i_pjcd_device_2 (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .link(link2), .pulse_form_switch_in(form), .negative_logic_in(neg),
    .position_method_setting_in(method), .param_speed_in(pspeed),
    .digital_switch_speed_in(pspeed[0]), .serial_speed_command_in(pspeed[2]),
    .speed_table_speed_in(pspeed[3]), .pulse_mode_out(pm2), .jog_mode_out(),
    .mode_conflict_out(mc2), .jog_run_out(), .jog_dir_out(), .jog_speed_out(),
    .position_target_out(), .feed_rate_out());
  pjcd_props i_pjcd_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .jog_mode_select_n(link.jog_mode_select_n), .pulse_mode_select_n(link.pulse_mode_select_n),
    .jog_forward_cmd_n(link.jog_forward_cmd_n), .jog_reverse_cmd_n(link.jog_reverse_cmd_n),
    .speed_select_second_n(link.speed_select_second_n),
    .speed_select_third_n(link.speed_select_third_n), .pulse_mode_out(pulse_mode_out),
    .mode_conflict_out(mode_conflict_out), .jog_run_out(jog_run_out),
    .jog_dir_out(jog_dir_out), .position_target_out(position_target_out));

  // Free-running system clock
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle register write
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  // Read data stand one cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Poll busy under a bound; a stuck burst shows as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus_rd(REG_STATUS, rd);
      n++;
    end while (rd[1] !== 1'b0 && n < 4000);
    check({31'h0, rd[1]}, 32'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {rst_in, wr_in, rd_in, addr_in, wdata_in, form, neg, method} = {1'b1, 50'h0};
    pspeed = {16'h0104, 16'h0103, 16'h0111, 16'h0101};
    {link2.cmd_pulse, link2.cmd_sign, link2.line_gen_active} = 3'h0;
    {link2.line_gen_step, link2.line_gen_dir} = 2'h0;
    {link2.jog_mode_select_n, link2.pulse_mode_select_n, link2.jog_forward_cmd_n} = 3'h7;
    {link2.jog_reverse_cmd_n, link2.speed_select_second_n, link2.speed_select_third_n} = 3'h7;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    bus_rd(REG_CTRL, rd);
    check(rd, {16'h0, CTRL_RESET});
    bus_rd(8'h0c, rd);
    check(rd, 32'h0);
    check(position_target_out, 32'h0);
    // Bursts: polarity changes only while pulse mode is off
    foreach (rows[i]) begin
      ctrl = 32'h0;
      ctrl[CB_SERVO_ON] = 1'b1;
      ctrl[CB_SP2] = rows[i].sp2;
      ctrl[CB_SP3] = rows[i].sp3;
      ctrl[CB_FORM_LO +: 3] = rows[i].form;
      ctrl[CB_NEG] = rows[i].neg;
      bus_wr(REG_CTRL, ctrl);
      form <= rows[i].form;
      neg <= rows[i].neg;
      repeat (8) @(posedge clk_sys_in);
      ctrl[CB_PULSE_MODE] = 1'b1;
      bus_wr(REG_CTRL, ctrl);
      repeat (8) @(posedge clk_sys_in);
      check(pulse_mode_out, 1'b1);
      p0 = position_target_out;
      bus_wr(REG_CMD, {rows[i].fwd, 15'h0, rows[i].cnt});
      wait_idle();
      repeat (10) @(posedge clk_sys_in);
      check(position_target_out - p0, rows[i].delta);
      ctrl[CB_PULSE_MODE] = 1'b0;
      bus_wr(REG_CTRL, ctrl);
    end
    // Jog forward, second select held, each source
    bus_wr(REG_CTRL, 32'h15);
    foreach (mtab[j]) begin
      method <= mtab[j];
      repeat (6) @(posedge clk_sys_in);
      check(jog_run_out, 1'b1);
      check(jog_dir_out, 1'b1);
      check(jog_speed_out, stab[j]);
    end
    foreach (jtab[j]) begin
      bus_wr(REG_CTRL, jtab[j]);
      repeat (6) @(posedge clk_sys_in);
      check(jog_run_out, jrun[j]);
      if (jrun[j]) begin
        check(jog_dir_out, 1'b0);
      end
    end
    // Line generator on the bench link blocks pulse mode
    link2.line_gen_active <= 1'b1;
    link2.pulse_mode_select_n <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    check(mc2, 1'b1);
    check(pm2, 1'b0);
    link2.line_gen_active <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    check(pm2, 1'b1);
    check(mc2, 1'b0);
    // Host holds pulse mode back while its generator bit is set
    bus_wr(REG_CTRL, 32'h82);
    repeat (6) @(posedge clk_sys_in);
    check(pulse_mode_out, 1'b0);
    // Two idle gates leave no feed rate
    repeat (2100) @(posedge clk_sys_in);
    check(feed_rate_out, 32'h0);
    // Second reset in mid-run clears travel and control
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1 check(position_target_out, 32'h0);
    bus_rd(REG_CTRL, rd);
    check(rd, 32'h0);
    give_verdict();
  end
endmodule
